// *** hdl/bav_pkg.sv ***
package bav_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam int NUM_BUCKS = 5;
   localparam logic [7:0] CORE1_ALT_OFS = 8'hb5;
   localparam logic [7:0] PROC_ALT_OFS = 8'hb6;
   localparam logic [7:0] MEM_ALT_OFS = 8'hb7;
   localparam logic [7:0] IO_ALT_OFS = 8'hb8;
   localparam logic [7:0] PERI_ALT_OFS = 8'hb9;

   // ----------------------------------------------------------------
   // Field layout
   // ----------------------------------------------------------------
   localparam int SLEEP_BIT = 7;
   localparam int VCODE_MSB = 6;
   localparam int VCODE_W = 7;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   // ----------------------------------------------------------------
   // Voltage scales in millivolts
   // ----------------------------------------------------------------
   localparam logic [11:0] CORE1_BASE_MV = 12'h12c;
   localparam logic [11:0] PROC_BASE_MV = 12'h212;
   localparam logic [11:0] WIDE_BASE_MV = 12'h320;
   localparam logic [11:0] FINE_STEP_MV = 12'h00a;
   localparam logic [11:0] WIDE_STEP_MV = 12'h014;

   // ----------------------------------------------------------------
   // Buck indices
   // ----------------------------------------------------------------
   localparam int IDX_CORE1 = 0;
   localparam int IDX_PROC = 1;
   localparam int IDX_MEM = 2;
   localparam int IDX_IO = 3;
   localparam int IDX_PERI = 4;

endpackage : bav_pkg

// *** hdl/bav_regs.sv ***
`timescale 1ns/1ps
module bav_regs (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Converter controls
   output logic [4:0] alt_sleep_select,
   output logic [34:0] alt_vcode,
   output logic [11:0] core1_target_mv,
   output logic [11:0] processor_target_mv,
   output logic [11:0] memory_target_mv,
   output logic [11:0] io_target_mv,
   output logic [11:0] peripheral_target_mv
);

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   function automatic logic [5:0] addr_sel(input logic [7:0] a);
      logic [5:0] s;
      s = 6'h00;
      unique case (a)
         bav_pkg::CORE1_ALT_OFS: s = 6'h01;
         bav_pkg::PROC_ALT_OFS: s = 6'h02;
         bav_pkg::MEM_ALT_OFS: s = 6'h04;
         bav_pkg::IO_ALT_OFS: s = 6'h08;
         bav_pkg::PERI_ALT_OFS: s = 6'h10;
         default: s = 6'h20;
      endcase
      return s;
   endfunction : addr_sel

   logic [7:0] alt_r [bav_pkg::NUM_BUCKS];
   logic [7:0] alt_nxt [bav_pkg::NUM_BUCKS];
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic [5:0] sel;
   logic [4:0] sleep_r;
   logic [4:0] sleep_nxt;
   logic [34:0] vcode_r;
   logic [34:0] vcode_nxt;

   assign sel = addr_sel(reg_addr);

   // ----------------------------------------------------------------
   // Register storage
   // ----------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < bav_pkg::NUM_BUCKS; i++) begin
         alt_nxt[i] = alt_r[i];
         if (reg_wr && sel[i]) begin
            alt_nxt[i] = reg_wdata;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < bav_pkg::NUM_BUCKS; i++) begin
            alt_r[i] <= bav_pkg::REG_RESET;
         end
      end else begin
         for (int i = 0; i < bav_pkg::NUM_BUCKS; i++) begin
            alt_r[i] <= alt_nxt[i];
         end
      end
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   always_comb begin
      rdata_nxt = bav_pkg::UNMAPPED_READ;
      if (reg_rd) begin
         for (int i = 0; i < bav_pkg::NUM_BUCKS; i++) begin
            if (sel[i]) begin
               rdata_nxt = alt_r[i];
            end
         end
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rdata_r <= 8'h00;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   assign reg_rdata = rdata_r;

   // ----------------------------------------------------------------
   // Mode and code outputs
   // ----------------------------------------------------------------
   // Outputs take the written value on the same edge as the register, so the converters see a registered,
   // glitch-free mode even while software rewrites the word.
   always_comb begin
      for (int i = 0; i < bav_pkg::NUM_BUCKS; i++) begin
         sleep_nxt[i] = alt_nxt[i][bav_pkg::SLEEP_BIT];
         vcode_nxt[i*7 +: 7] = alt_nxt[i][bav_pkg::VCODE_MSB:0];
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         sleep_r <= 5'h00;
         vcode_r <= 35'h0;
      end else begin
         sleep_r <= sleep_nxt;
         vcode_r <= vcode_nxt;
      end
   end

   assign alt_sleep_select = sleep_r;
   assign alt_vcode = vcode_r;

   // ----------------------------------------------------------------
   // Target voltage decode
   // ----------------------------------------------------------------
   // core1 fine scale
   bav_volt_map #(.BASE_MV(bav_pkg::CORE1_BASE_MV), .STEP_MV(bav_pkg::FINE_STEP_MV)) u_core1 (
      .core_clk(core_clk), .rstn(rstn), .vcode(vcode_r[6:0]), .target_mv(core1_target_mv));
   bav_volt_map #(.BASE_MV(bav_pkg::PROC_BASE_MV), .STEP_MV(bav_pkg::FINE_STEP_MV)) u_proc (
      .core_clk(core_clk), .rstn(rstn), .vcode(vcode_r[13:7]), .target_mv(processor_target_mv));
   bav_volt_map #(.BASE_MV(bav_pkg::WIDE_BASE_MV), .STEP_MV(bav_pkg::WIDE_STEP_MV)) u_mem (
      .core_clk(core_clk), .rstn(rstn), .vcode(vcode_r[20:14]), .target_mv(memory_target_mv));
   bav_volt_map #(.BASE_MV(bav_pkg::WIDE_BASE_MV), .STEP_MV(bav_pkg::WIDE_STEP_MV)) u_io (
      .core_clk(core_clk), .rstn(rstn), .vcode(vcode_r[27:21]), .target_mv(io_target_mv));
   bav_volt_map #(.BASE_MV(bav_pkg::WIDE_BASE_MV), .STEP_MV(bav_pkg::WIDE_STEP_MV)) u_peri (
      .core_clk(core_clk), .rstn(rstn), .vcode(vcode_r[34:28]), .target_mv(peripheral_target_mv));

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   // core1 target value
   core1_target_a: assert property (@(posedge core_clk) disable iff (!rstn)
      reg_wr && reg_addr == bav_pkg::CORE1_ALT_OFS ##2 1 |-> core1_target_mv ==
      12'(12'd300 + 12'd10 * 12'($past(reg_wdata[6:0], 2))))
      else $error("core1 target wrong");
   proc_target_a: assert property (@(posedge core_clk) disable iff (!rstn)
      vcode_r[13:7] == 7'h43 |=> processor_target_mv == 12'd1200)
      else $error("processor target wrong");
   wide_top_a: assert property (@(posedge core_clk) disable iff (!rstn)
      vcode_r[20:14] == 7'h7f |=> memory_target_mv == 12'd3340)
      else $error("memory top wrong");
   io_base_a: assert property (@(posedge core_clk) disable iff (!rstn)
      rstn && vcode_r[27:21] == 7'h00 |=> io_target_mv == 12'd800)
      else $error("io base wrong");
   mem_sleep_a: assert property (@(posedge core_clk) disable iff (!rstn)
      reg_wr && reg_addr == bav_pkg::MEM_ALT_OFS |=> alt_sleep_select[2] == $past(reg_wdata[7]))
      else $error("memory sleep wrong");
   io_sleep_a: assert property (@(posedge core_clk) disable iff (!rstn)
      reg_wr && reg_addr == bav_pkg::IO_ALT_OFS |=> alt_sleep_select[3] == $past(reg_wdata[7]))
      else $error("io sleep wrong");
   peri_sleep_a: assert property (@(posedge core_clk) disable iff (!rstn)
      reg_wr && reg_addr == bav_pkg::PERI_ALT_OFS |=> alt_sleep_select[4] == $past(reg_wdata[7]))
      else $error("peripheral sleep wrong");
   cp_sleep_a: assert property (@(posedge core_clk) disable iff (!rstn)
      reg_wr && reg_addr == bav_pkg::PROC_ALT_OFS |=> alt_sleep_select[1] == $past(reg_wdata[7])
      && alt_vcode[13:7] == $past(reg_wdata[6:0]))
      else $error("processor word wrong");
   read_back_a: assert property (@(posedge core_clk) disable iff (!rstn)
      reg_rd && reg_addr == bav_pkg::CORE1_ALT_OFS |=> reg_rdata == {alt_sleep_select[0], alt_vcode[6:0]})
      else $error("read back wrong");
   core1_base_a: assert property (@(posedge core_clk) disable iff (!rstn)
      rstn && vcode_r[6:0] == 7'h00
      |=> core1_target_mv == 12'd300)
      else $error("core1 base wrong");
   core1_top_a: assert property (@(posedge core_clk) disable iff (!rstn)
      vcode_r[6:0] == 7'h7f
      |=> core1_target_mv == 12'd1570)
      else $error("core1 top wrong");
   core1_word_a: assert property (@(posedge core_clk) disable iff (!rstn)
      reg_wr && reg_addr == bav_pkg::CORE1_ALT_OFS
      |=> alt_sleep_select[0] == $past(reg_wdata[7]) && alt_vcode[6:0] == $past(reg_wdata[6:0]))
      else $error("core1 word wrong");
   proc_base_a: assert property (@(posedge core_clk) disable iff (!rstn)
      rstn && vcode_r[13:7] == 7'h00
      |=> processor_target_mv == 12'd530)
      else $error("processor base wrong");
   proc_step_a: assert property (@(posedge core_clk) disable iff (!rstn)
      reg_wr && reg_addr == bav_pkg::PROC_ALT_OFS ##2 1
      |-> processor_target_mv == 12'(12'd530 + 12'd10 * 12'($past(reg_wdata[6:0], 2))))
      else $error("processor step wrong");
   proc_top_a: assert property (@(posedge core_clk) disable iff (!rstn)
      vcode_r[13:7] == 7'h7f
      |=> processor_target_mv == 12'd1800)
      else $error("processor top wrong");
   mem_base_a: assert property (@(posedge core_clk) disable iff (!rstn)
      rstn && vcode_r[20:14] == 7'h00
      |=> memory_target_mv == 12'd800)
      else $error("memory base wrong");
   mem_step_a: assert property (@(posedge core_clk) disable iff (!rstn)
      reg_wr && reg_addr == bav_pkg::MEM_ALT_OFS ##2 1
      |-> memory_target_mv == 12'(12'd800 + 12'd20 * 12'($past(reg_wdata[6:0], 2))))
      else $error("memory step wrong");
   mem_code_a: assert property (@(posedge core_clk) disable iff (!rstn)
      reg_wr && reg_addr == bav_pkg::MEM_ALT_OFS
      |=> alt_vcode[20:14] == $past(reg_wdata[6:0]))
      else $error("memory code wrong");
   io_top_a: assert property (@(posedge core_clk) disable iff (!rstn)
      vcode_r[27:21] == 7'h7f
      |=> io_target_mv == 12'd3340)
      else $error("io top wrong");
   io_step_a: assert property (@(posedge core_clk) disable iff (!rstn)
      reg_wr && reg_addr == bav_pkg::IO_ALT_OFS ##2 1
      |-> io_target_mv == 12'(12'd800 + 12'd20 * 12'($past(reg_wdata[6:0], 2))))
      else $error("io step wrong");
   io_code_a: assert property (@(posedge core_clk) disable iff (!rstn)
      reg_wr && reg_addr == bav_pkg::IO_ALT_OFS
      |=> alt_vcode[27:21] == $past(reg_wdata[6:0]))
      else $error("io code wrong");
   peri_base_a: assert property (@(posedge core_clk) disable iff (!rstn)
      rstn && vcode_r[34:28] == 7'h00
      |=> peripheral_target_mv == 12'd800)
      else $error("peripheral base wrong");
   peri_step_a: assert property (@(posedge core_clk) disable iff (!rstn)
      reg_wr && reg_addr == bav_pkg::PERI_ALT_OFS ##2 1
      |-> peripheral_target_mv == 12'(12'd800 + 12'd20 * 12'($past(reg_wdata[6:0], 2))))
      else $error("peripheral step wrong");
   peri_code_a: assert property (@(posedge core_clk) disable iff (!rstn)
      reg_wr && reg_addr == bav_pkg::PERI_ALT_OFS
      |=> alt_vcode[34:28] == $past(reg_wdata[6:0]))
      else $error("peripheral code wrong");
   read_proc_a: assert property (@(posedge core_clk) disable iff (!rstn)
      reg_rd && reg_addr == bav_pkg::PROC_ALT_OFS
      |=> reg_rdata == {alt_sleep_select[1], alt_vcode[13:7]})
      else $error("processor read wrong");
   read_mem_a: assert property (@(posedge core_clk) disable iff (!rstn)
      reg_rd && reg_addr == bav_pkg::MEM_ALT_OFS
      |=> reg_rdata == {alt_sleep_select[2], alt_vcode[20:14]})
      else $error("memory read wrong");
   read_io_a: assert property (@(posedge core_clk) disable iff (!rstn)
      reg_rd && reg_addr == bav_pkg::IO_ALT_OFS
      |=> reg_rdata == {alt_sleep_select[3], alt_vcode[27:21]})
      else $error("io read wrong");
   read_peri_a: assert property (@(posedge core_clk) disable iff (!rstn)
      reg_rd && reg_addr == bav_pkg::PERI_ALT_OFS
      |=> reg_rdata == {alt_sleep_select[4], alt_vcode[34:28]})
      else $error("peripheral read wrong");
   // Read data fall back to zero outside the answering cycle.
   rdata_idle_a: assert property (@(posedge core_clk) disable iff (!rstn)
      !reg_rd
      |=> reg_rdata == bav_pkg::UNMAPPED_READ)
      else $error("idle read data wrong");
   // Writes outside the map leave every converter setting alone.
   unmapped_wr_a: assert property (@(posedge core_clk) disable iff (!rstn)
      reg_wr && (reg_addr < bav_pkg::CORE1_ALT_OFS || reg_addr > bav_pkg::PERI_ALT_OFS)
      |=> $stable(alt_sleep_select) && $stable(alt_vcode))
      else $error("unmapped write changed a setting");
   // Every setting is cleared while reset is held.
   rst_clear_a: assert property (@(posedge core_clk)
      !rstn ##1 !rstn
      |-> alt_sleep_select == 5'h00 && alt_vcode == 35'h0 && reg_rdata == 8'h00 && core1_target_mv == 12'h000)
      else $error("reset state wrong");

   wr_core1_c: cover property (@(posedge core_clk) disable iff (!rstn)
      reg_wr && reg_addr == bav_pkg::CORE1_ALT_OFS);
   rd_peri_c: cover property (@(posedge core_clk) disable iff (!rstn)
      reg_rd && reg_addr == bav_pkg::PERI_ALT_OFS);
   sleep_mem_c: cover property (@(posedge core_clk) disable iff (!rstn) alt_sleep_select[2]);
   unmapped_c: cover property (@(posedge core_clk) disable iff (!rstn) reg_rd && sel[5]);
   wr_then_rd_c: cover property (@(posedge core_clk) disable iff (!rstn) reg_wr ##1 reg_rd);

endmodule : bav_regs

// *** hdl/bav_volt_map.sv ***
`timescale 1ns/1ps
module bav_volt_map #(
   parameter logic [11:0] BASE_MV = 12'h000,
   parameter logic [11:0] STEP_MV = 12'h000
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // Code in, target out
   input wire logic [6:0] vcode,
   output logic [11:0] target_mv
);

   logic [11:0] target_nxt;

   always_comb begin
      target_nxt = 12'(BASE_MV + 12'({5'h00, vcode}) * STEP_MV);
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         target_mv <= 12'h000;
      end else begin
         target_mv <= target_nxt;
      end
   end

endmodule : bav_volt_map

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
   // ----------------------------------------------------------------
   // Stimulus signals and design
   // ----------------------------------------------------------------
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic [4:0] alt_sleep_select;
   logic [34:0] alt_vcode;
   logic [11:0] core1_mv;
   logic [11:0] proc_mv;
   logic [11:0] mem_mv;
   logic [11:0] io_mv;
   logic [11:0] peri_mv;
   logic [11:0] tgt [5];
   int err_total = 0;
   int num_checks = 0;

   always #5 core_clk = ~core_clk;

   bav_regs dut (.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .alt_sleep_select(alt_sleep_select), .alt_vcode(alt_vcode),
      .core1_target_mv(core1_mv), .processor_target_mv(proc_mv), .memory_target_mv(mem_mv),
      .io_target_mv(io_mv), .peripheral_target_mv(peri_mv));

   always_comb begin
      tgt[0] = core1_mv;
      tgt[1] = proc_mv;
      tgt[2] = mem_mv;
      tgt[3] = io_mv;
      tgt[4] = peri_mv;
   end

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t ns: seen 0x%0h expected 0x%0h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr

   // The read data stand for one cycle only, so they are taken just after the answering edge.
   task automatic rd(input logic [7:0] a, output logic [7:0] q);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      q = reg_rdata;
   endtask : rd

   task automatic buck_case(input int idx, input logic [7:0] ofs, input logic [11:0] base,
                            input logic [11:0] step, input logic [7:0] d);
      logic [7:0] q;
      wr(ofs, d);
      #1;
      chk(12'(alt_sleep_select[idx]), 12'(d[7]));
      chk(12'(alt_vcode[idx*7 +: 7]), 12'(d[6:0]));
      @(posedge core_clk);
      #1;
      chk(tgt[idx], base + step * 12'(d[6:0]));
      rd(ofs, q);
      chk(12'(q), 12'(d));
   endtask : buck_case

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic test_reset();
      logic [7:0] q;
      for (int i = 0; i < 5; i++) begin
         rd(8'hb5 + 8'(i), q);
         chk(12'(q), 12'h000);
      end
      chk(tgt[0], 12'h12c);
      chk(tgt[1], 12'h212);
      for (int i = 2; i < 5; i++) begin
         chk(tgt[i], 12'h320);
      end
   endtask : test_reset

   // Writes outside the map must leave every converter setting untouched.
   task automatic test_unmapped();
      logic [7:0] q;
      wr(8'hba, 8'hff);
      wr(8'hb4, 8'hff);
      rd(8'hba, q);
      chk(12'(q), 12'h000);
      chk(12'(alt_sleep_select), 12'h000);
      chk(12'(|alt_vcode), 12'h000);
   endtask : test_unmapped

   task automatic test_core1();
      buck_case(0, 8'hb5, 12'h12c, 12'h00a, 8'h80);
      buck_case(0, 8'hb5, 12'h12c, 12'h00a, 8'h7f);
   endtask : test_core1

   task automatic test_proc();
      buck_case(1, 8'hb6, 12'h212, 12'h00a, 8'h43);
      chk(tgt[1], 12'h4b0);
      buck_case(1, 8'hb6, 12'h212, 12'h00a, 8'hc5);
      buck_case(1, 8'hb6, 12'h212, 12'h00a, 8'hff);
   endtask : test_proc

   task automatic test_mem();
      buck_case(2, 8'hb7, 12'h320, 12'h014, 8'h85);
      buck_case(2, 8'hb7, 12'h320, 12'h014, 8'h7f);
      chk(tgt[2], 12'hd0c);
   endtask : test_mem

   task automatic test_io();
      buck_case(3, 8'hb8, 12'h320, 12'h014, 8'h94);
      buck_case(3, 8'hb8, 12'h320, 12'h014, 8'h3c);
      buck_case(3, 8'hb8, 12'h320, 12'h014, 8'hff);
   endtask : test_io

   task automatic test_peri();
      buck_case(4, 8'hb9, 12'h320, 12'h014, 8'hb2);
      buck_case(4, 8'hb9, 12'h320, 12'h014, 8'h7f);
   endtask : test_peri

   // A read straight after a write to the same place must return the new value.
   task automatic test_back_to_back();
      @(posedge core_clk);
      reg_addr <= 8'hb8;
      reg_wdata <= 8'h21;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      chk(12'(reg_rdata), 12'h021);
      @(posedge core_clk);
      #1;
      chk(12'(reg_rdata), 12'h000);
   endtask : test_back_to_back

   // A reset in mid-run must clear every setting; the memory target returns to its base value after it.
   task automatic test_mid_reset();
      logic [7:0] q;
      wr(8'hb7, 8'hd5);
      #1;
      chk(12'(alt_sleep_select[2]), 12'h001);
      @(posedge core_clk);
      rstn <= 1'b0;
      @(posedge core_clk);
      #1;
      chk(12'(alt_sleep_select), 12'h000);
      chk(12'(|alt_vcode), 12'h000);
      chk(tgt[2], 12'h000);
      repeat (2) @(posedge core_clk);
      rstn <= 1'b1;
      repeat (2) @(posedge core_clk);
      #1;
      chk(tgt[2], 12'h320);
      rd(8'hb7, q);
      chk(12'(q), 12'h000);
   endtask : test_mid_reset

   task automatic complete_run();
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : complete_run

   initial begin
      repeat (8) @(posedge core_clk);
      rstn <= 1'b1;
      test_reset();
      test_unmapped();
      test_core1();
      test_proc();
      test_mem();
      test_io();
      test_peri();
      test_back_to_back();
      test_mid_reset();
      complete_run();
   end
endmodule : tb_top
